// File: design/pec_regs.svh
// constants for the two-counter event selection and counting block
// assumes inclusion by bare name from every design file that needs offsets or codes
`ifndef PEC_REGS_SVH
`define PEC_REGS_SVH

`define PEC_CODE_W 6
`define PEC_CTR_W 40
`define PEC_DATA_W 64
`define PEC_IDX_W 32

`define PEC_EV_MUL_STORE 6'h38
`define PEC_EV_RETURNS 6'h39
`define PEC_EV_BRANCH_BUF 6'h3A
`define PEC_EV_WRITE_STALL 6'h3B

`define PEC_IDX_CTL 32'h0000_0011
`define PEC_IDX_CTR0 32'h0000_0012
`define PEC_IDX_CTR1 32'h0000_0013

`define PEC_CTL_SEL0_LSB 0
`define PEC_CTL_SEL1_LSB 16
`define PEC_CTL_RST 64'h0000_0000_0000_0000
`define PEC_CTR_RST 40'h00_0000_0000

`endif

// File: design/pec_pkg.sv
// types shared by the event selector and the counter top
// assumes the constants header is visible through the include below
`include "pec_regs.svh"

package pec_pkg;

    typedef logic [`PEC_CODE_W-1:0] pec_code_t;
    typedef logic [`PEC_CTR_W-1:0] pec_count_t;

    // per-clock indications from the pipeline, branch buffer and write buffers
    typedef struct packed {
        logic multiply_interlock_stall_event;
        logic other_stall_cause;
        logic move_store_d2_stall;
        logic near_return_instr_exec;
        logic interrupt_return_instr;
        logic return_exception;
        logic interrupt_before_return;
        logic branch_buffer_false_entry_event;
        logic branch_taken_not_taken;
        logic write_buffer_full_stall;
        logic em_line_write_stall;
    } pec_evt_s;

    typedef enum logic [0:0] {
        PEC_CTR0,
        PEC_CTR1
    } pec_ctr_e;

endpackage : pec_pkg

// File: design/pec_evt_sel.sv
// event selector: turns the two programmed codes into one increment per counter
// assumes event inputs come from logic on the same clock, already qualified per clock
`timescale 1ns/1ps
`include "pec_regs.svh"

module pec_evt_sel
    import pec_pkg::*;
(
    input wire pec_evt_s evt,
    input wire pec_code_t sel0,
    input wire pec_code_t sel1,
    output logic inc0,
    output logic inc1
);

    wire multiply_only = evt.multiply_interlock_stall_event & ~evt.other_stall_cause;
    wire return_hit = (evt.near_return_instr_exec & ~evt.interrupt_return_instr)
                      | evt.return_exception | evt.interrupt_before_return;

    function automatic logic pec_hit(input pec_code_t code, input pec_ctr_e ctr, input pec_evt_s e,
                                     input logic mul_only, input logic ret_hit);
        logic hit;
        hit = 1'b0;
        case (code)
            `PEC_EV_MUL_STORE: begin
                // interlock length already encodes two clocks or one per occurrence
                hit = (ctr == PEC_CTR0) ? mul_only : e.move_store_d2_stall;
            end
            `PEC_EV_RETURNS: begin
                hit = (ctr == PEC_CTR0) ? ret_hit : 1'b0;
            end
            `PEC_EV_BRANCH_BUF: begin
                hit = (ctr == PEC_CTR0) ? e.branch_buffer_false_entry_event : e.branch_taken_not_taken;
            end
            `PEC_EV_WRITE_STALL: begin
                hit = (ctr == PEC_CTR0) ? e.write_buffer_full_stall : e.em_line_write_stall;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction : pec_hit

    assign inc0 = pec_hit(sel0, PEC_CTR0, evt, multiply_only, return_hit);
    assign inc1 = pec_hit(sel1, PEC_CTR1, evt, multiply_only, return_hit);

endmodule : pec_evt_sel

// File: design/pec_counters.sv
// two event counters, their select register and the model-register access port
// assumes the pipeline drives events and access strobes from clk_sys, one access per clock at most
`timescale 1ns/1ps
`include "pec_regs.svh"

module pec_counters
    import pec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire pec_evt_s evt,
    input wire logic model_reg_read_instr,
    input wire logic model_reg_write_instr,
    input wire logic [`PEC_IDX_W-1:0] model_reg_index,
    input wire logic [`PEC_DATA_W-1:0] model_reg_wdata,
    output logic [`PEC_DATA_W-1:0] model_reg_rdata,
    output logic model_reg_rvalid,
    output logic model_reg_fault,
    output pec_count_t ctr0,
    output pec_count_t ctr1
);

    logic [`PEC_DATA_W-1:0] ctl;
    logic inc0;
    logic inc1;

    wire hit_ctl = (model_reg_index == `PEC_IDX_CTL);
    wire hit_ctr0 = (model_reg_index == `PEC_IDX_CTR0);
    wire hit_ctr1 = (model_reg_index == `PEC_IDX_CTR1);
    wire hit_any = hit_ctl | hit_ctr0 | hit_ctr1;
    wire wr_ctl = model_reg_write_instr & hit_ctl;
    wire wr_ctr0 = model_reg_write_instr & hit_ctr0;
    wire wr_ctr1 = model_reg_write_instr & hit_ctr1;
    wire access = model_reg_read_instr | model_reg_write_instr;
    wire pec_code_t sel0 = ctl[`PEC_CTL_SEL0_LSB +: `PEC_CODE_W];
    wire pec_code_t sel1 = ctl[`PEC_CTL_SEL1_LSB +: `PEC_CODE_W];

    // only the two select fields are stored; the rest of the control word reads as zero
    wire [`PEC_DATA_W-1:0] ctl_keep = (64'h0000_0000_0000_003F << `PEC_CTL_SEL0_LSB)
                                    | (64'h0000_0000_0000_003F << `PEC_CTL_SEL1_LSB);

    logic [`PEC_DATA_W-1:0] read_mux;
    always_comb begin
        read_mux = 64'h0000_0000_0000_0000;
        if (hit_ctl) begin
            read_mux = ctl;
        end else if (hit_ctr0) begin
            read_mux = {24'h00_0000, ctr0};
        end else if (hit_ctr1) begin
            read_mux = {24'h00_0000, ctr1};
        end
    end

    wire pec_count_t next_ctr0 = wr_ctr0 ? model_reg_wdata[`PEC_CTR_W-1:0] : ctr0 + {39'h0, inc0};
    wire pec_count_t next_ctr1 = wr_ctr1 ? model_reg_wdata[`PEC_CTR_W-1:0] : ctr1 + {39'h0, inc1};

    pec_evt_sel u_sel (
        .evt(evt),
        .sel0(sel0),
        .sel1(sel1),
        .inc0(inc0),
        .inc1(inc1)
    );

    // a software write in the same clock as an event wins; the event in that clock is dropped
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctr0 <= `PEC_CTR_RST;
            ctr1 <= `PEC_CTR_RST;
        end else begin
            ctr0 <= next_ctr0;
            ctr1 <= next_ctr1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctl <= `PEC_CTL_RST;
        end else if (wr_ctl) begin
            ctl <= model_reg_wdata & ctl_keep;
        end
    end

    // read data is captured before this clock's increment, so it shows the pre-edge count
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            model_reg_rdata <= 64'h0000_0000_0000_0000;
            model_reg_rvalid <= 1'b0;
            model_reg_fault <= 1'b0;
        end else begin
            model_reg_rdata <= model_reg_read_instr ? read_mux : 64'h0000_0000_0000_0000;
            model_reg_rvalid <= model_reg_read_instr & hit_any;
            model_reg_fault <= access & ~hit_any;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    wire mul_only0 = (sel0 == `PEC_EV_MUL_STORE) && evt.multiply_interlock_stall_event
                     && !evt.other_stall_cause && !wr_ctr0 && !wr_ctl;

    wire pec_count_t wdata_cnt = model_reg_wdata[`PEC_CTR_W-1:0];
    wire mul_quiet0 = (sel0 == `PEC_EV_MUL_STORE) && !evt.multiply_interlock_stall_event
                      && !wr_ctr0 && !wr_ctl;
    wire sel0_counts = (sel0 == `PEC_EV_MUL_STORE) || (sel0 == `PEC_EV_RETURNS)
                       || (sel0 == `PEC_EV_BRANCH_BUF) || (sel0 == `PEC_EV_WRITE_STALL);
    // 39H means nothing on counter 1, so it is left out here on purpose
    wire sel1_counts = (sel1 == `PEC_EV_MUL_STORE) || (sel1 == `PEC_EV_BRANCH_BUF)
                       || (sel1 == `PEC_EV_WRITE_STALL);

    sequence s_two_interlock_clocks;
        mul_only0 [*2];
    endsequence

    sequence s_one_interlock_clock;
        mul_only0 ##1 mul_quiet0;
    endsequence

    AST_MUL_COUNTS: assert property (
        mul_only0 |=> ctr0 == $past(ctr0) + 40'h1
    ) else $error("interlock stall clock not counted on counter 0");

    AST_MUL_OTHER_STALL: assert property (
        (sel0 == `PEC_EV_MUL_STORE) && evt.other_stall_cause && !wr_ctr0 && !wr_ctl |=> $stable(ctr0)
    ) else $error("interlock counted while another stall cause present");

    AST_MUL_TWO_CLOCKS: assert property (
        s_two_interlock_clocks |=> ctr0 == $past(ctr0, 2) + 40'h2
    ) else $error("two-clock interlock did not add two counts");

    AST_STORE_D2: assert property (
        (sel1 == `PEC_EV_MUL_STORE) && evt.move_store_d2_stall && !wr_ctr1 && !wr_ctl
        |=> ctr1 == $past(ctr1) + 40'h1
    ) else $error("store stall in D2 not counted on counter 1");

    AST_IRQ_RETURN_IGNORED: assert property (
        (sel0 == `PEC_EV_RETURNS) && evt.near_return_instr_exec && evt.interrupt_return_instr
        && !evt.return_exception && !evt.interrupt_before_return && !wr_ctr0 && !wr_ctl |=> $stable(ctr0)
    ) else $error("interrupt return was counted");

    AST_RETURN_EXCEPTION: assert property (
        (sel0 == `PEC_EV_RETURNS) && (evt.return_exception || evt.interrupt_before_return) && !wr_ctr0 && !wr_ctl
        |=> ctr0 == $past(ctr0) + 40'h1
    ) else $error("exception or interrupt on return not counted");

    AST_FALSE_ENTRY: assert property (
        (sel0 == `PEC_EV_BRANCH_BUF) && evt.branch_buffer_false_entry_event && !wr_ctr0 && !wr_ctl
        |=> ctr0 == $past(ctr0) + 40'h1
    ) else $error("false branch-buffer entry not counted");

    AST_TAKEN_NOT_TAKEN: assert property (
        (sel1 == `PEC_EV_BRANCH_BUF) && !evt.branch_taken_not_taken && !wr_ctr1 && !wr_ctl |=> $stable(ctr1)
    ) else $error("counter 1 moved without a taken-not-taken misprediction");

    AST_WRITE_BUF_FULL: assert property (
        (sel0 == `PEC_EV_WRITE_STALL) && evt.write_buffer_full_stall && !wr_ctr0 && !wr_ctl
        |=> ctr0 == $past(ctr0) + 40'h1
    ) else $error("full write buffer stall not counted");

    AST_EM_LINE_STALL: assert property (
        (sel1 == `PEC_EV_WRITE_STALL) && evt.em_line_write_stall && !wr_ctr1 && !wr_ctl
        |=> ctr1 == $past(ctr1) + 40'h1
    ) else $error("E or M line write stall not counted");

    AST_WRITE_THEN_READ: assert property (
        wr_ctr1 ##1 (model_reg_read_instr && hit_ctr1 && !model_reg_write_instr && !inc1)
        |=> model_reg_rvalid && model_reg_rdata[`PEC_CTR_W-1:0] == $past(wdata_cnt, 2)
    ) else $error("counter 1 read did not return the written value");

    AST_RESERVED_PAIR: assert property (
        (sel1 == `PEC_EV_RETURNS) && !wr_ctr1 && !wr_ctl |=> $stable(ctr1)
    ) else $error("reserved code on counter 1 produced a count");

    AST_MUL_ONE_CLOCK: assert property (
        s_one_interlock_clock
        |=> ctr0 == $past(ctr0, 2) + 40'h1
    ) else $error("one-clock interlock did not add exactly one count");

    AST_STORE_IDLE: assert property (
        (sel1 == `PEC_EV_MUL_STORE) && !evt.move_store_d2_stall && !wr_ctr1 && !wr_ctl
        |=> $stable(ctr1)
    ) else $error("counter 1 moved without a store stall in D2");

    AST_RETURN_COUNTED: assert property (
        (sel0 == `PEC_EV_RETURNS) && evt.near_return_instr_exec && !evt.interrupt_return_instr && !wr_ctr0 && !wr_ctl
        |=> ctr0 == $past(ctr0) + 40'h1
    ) else $error("executed near return not counted");

    AST_CTR0_WRITE: assert property (
        wr_ctr0
        |=> ctr0 == $past(wdata_cnt)
    ) else $error("counter 0 write did not land");

    AST_CTR1_WRITE: assert property (
        wr_ctr1
        |=> ctr1 == $past(wdata_cnt)
    ) else $error("counter 1 write did not land");

    AST_CTL_WRITE: assert property (
        wr_ctl
        |=> ctl == ($past(model_reg_wdata) & ctl_keep)
    ) else $error("control write did not land");

    AST_READ_ANSWER: assert property (
        model_reg_read_instr && hit_any
        |=> model_reg_rvalid && !model_reg_fault
    ) else $error("mapped read gave no answer");

    AST_UNMAPPED_FAULT: assert property (
        (model_reg_read_instr || model_reg_write_instr) && !hit_any
        |=> model_reg_fault && !model_reg_rvalid && model_reg_rdata == 64'h0000_0000_0000_0000
    ) else $error("unmapped access did not fault cleanly");

    AST_PORT_IDLE: assert property (
        !model_reg_read_instr && !model_reg_write_instr
        |=> !model_reg_rvalid && !model_reg_fault && model_reg_rdata == 64'h0000_0000_0000_0000
    ) else $error("register port answered without an access");

    AST_CTR0_NO_CODE: assert property (
        !sel0_counts && !wr_ctr0
        |=> $stable(ctr0)
    ) else $error("counter 0 moved with no event code selected");

    AST_CTR1_NO_CODE: assert property (
        !sel1_counts && !wr_ctr1
        |=> $stable(ctr1)
    ) else $error("counter 1 moved with no event code selected");

endmodule : pec_counters

// File: tb/pec_pipe_model.sv
// pipeline-side source of the per-clock event levels and pulses
// assumes the bench feeds fresh random bits each clock and gates activity with run
`timescale 1ns/1ps

module pec_pipe_model
    import pec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [15:0] rnd,
    output pec_evt_s evt
);
    logic [1:0] mul_left;
    logic mul_go;
    assign mul_go = run && mul_left == 2'h0 && rnd[0];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            evt <= '0;
            mul_left <= 2'h0;
        end else begin
            // dependent op right after the multiply stalls two clocks, one clock later stalls one
            mul_left <= mul_go ? {1'b0, rnd[1]} : (mul_left != 2'h0 ? mul_left - 2'h1 : 2'h0);
            evt.multiply_interlock_stall_event <= run && (mul_go || mul_left != 2'h0);
            evt.other_stall_cause <= run & rnd[2];
            evt.move_store_d2_stall <= run & rnd[3];
            evt.near_return_instr_exec <= run & rnd[4];
            // interrupt-return only qualifies an executed return
            evt.interrupt_return_instr <= run & rnd[4] & rnd[5];
            evt.return_exception <= run & rnd[6] & rnd[7];
            evt.interrupt_before_return <= run & rnd[8] & rnd[9];
            evt.branch_buffer_false_entry_event <= run & rnd[10];
            evt.branch_taken_not_taken <= run & rnd[11];
            evt.write_buffer_full_stall <= run & rnd[12];
            evt.em_line_write_stall <= run & rnd[13];
        end
    end
endmodule : pec_pipe_model

// File: tb/pec_counters_tb_top.sv
// self-checking bench for the two event counters and their register port
// assumes the pipeline model drives events; accesses are made only while events are idle
`timescale 1ns/1ps
`include "pec_regs.svh"

module pec_counters_tb_top
    import pec_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic run = 1'b0;
    logic [15:0] rnd = 16'h0000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] idx = 32'h0000_0000;
    logic [63:0] wdata = 64'h0;
    logic [63:0] rdata;
    logic rvalid;
    logic fault;
    pec_evt_s evt;
    pec_count_t ctr0;
    pec_count_t ctr1;
    logic [65:0] notes[$];
    int fails = 0;
    int checks = 0;
    int cycles = 0;
    logic [63:0] exp0 = 64'h0;
    logic [63:0] exp1 = 64'h0;
    pec_code_t s0 = 6'h00;
    pec_code_t s1 = 6'h00;

    always #4 clk_sys = ~clk_sys;

    pec_pipe_model u_pec_pipe_model (.clk_sys(clk_sys), .reset_n(reset_n), .run(run), .rnd(rnd), .evt(evt));
    pec_counters u_pec_counters (.clk_sys(clk_sys), .reset_n(reset_n), .evt(evt),
        .model_reg_read_instr(rd), .model_reg_write_instr(wr), .model_reg_index(idx),
        .model_reg_wdata(wdata), .model_reg_rdata(rdata), .model_reg_rvalid(rvalid),
        .model_reg_fault(fault), .ctr0(ctr0), .ctr1(ctr1));

    function automatic logic f0(pec_code_t c, pec_evt_s e);
        case (c)
            `PEC_EV_MUL_STORE: return e.multiply_interlock_stall_event & ~e.other_stall_cause;
            `PEC_EV_RETURNS: return (e.near_return_instr_exec & ~e.interrupt_return_instr)
                | e.return_exception | e.interrupt_before_return;
            `PEC_EV_BRANCH_BUF: return e.branch_buffer_false_entry_event;
            `PEC_EV_WRITE_STALL: return e.write_buffer_full_stall;
            default: return 1'b0;
        endcase
    endfunction : f0

    function automatic logic f1(pec_code_t c, pec_evt_s e);
        case (c)
            `PEC_EV_MUL_STORE: return e.move_store_d2_stall;
            `PEC_EV_BRANCH_BUF: return e.branch_taken_not_taken;
            `PEC_EV_WRITE_STALL: return e.em_line_write_stall;
            default: return 1'b0;
        endcase
    endfunction : f1

    task automatic close_out();
        // an answer that never came leaves its note behind
        if (notes.size() != 0)
            fails++;
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out

    task automatic cmp_result(input logic [65:0] want, input logic [65:0] got);
        checks++;
        if (got !== want) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask : cmp_result

    // counters wrap at 40 bits, so the model sum is masked to match
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            exp0 = (exp0 + 64'(f0(s0, evt))) & 64'h0000_00FF_FFFF_FFFF;
            exp1 = (exp1 + 64'(f1(s1, evt))) & 64'h0000_00FF_FFFF_FFFF;
            rnd <= 16'($urandom());
        end
    endtask : tick

    task automatic wr_reg(input logic [31:0] i, input logic f, input logic [63:0] d);
        if (f)
            notes.push_back({2'b01, 64'h0});
        @(posedge clk_sys);
        wr <= 1'b1;
        idx <= i;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [31:0] i, input logic f, input logic [63:0] d);
        notes.push_back({~f, f, d});
        @(posedge clk_sys);
        rd <= 1'b1;
        idx <= i;
        @(posedge clk_sys);
        rd <= 1'b0;
    endtask : rd_reg

    always @(posedge clk_sys) begin
        if (rvalid === 1'b1 || fault === 1'b1)
            cmp_result(notes.size() != 0 ? notes.pop_front() : 66'hx, {rvalid, fault, rdata});
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        static pec_code_t codes[5] = '{6'h38, 6'h39, 6'h3A, 6'h3B, 6'h3C};
        logic [63:0] w;
        void'($urandom(13783));
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd_reg(`PEC_IDX_CTL, 1'b0, `PEC_CTL_RST);
        foreach (codes[k]) begin
            w = {$urandom(), $urandom()};
            w[5:0] = codes[k];
            w[21:16] = codes[k];
            wr_reg(`PEC_IDX_CTL, 1'b0, w);
            rd_reg(`PEC_IDX_CTL, 1'b0, {42'h0, w[21:16], 10'h0, w[5:0]});
            s0 = codes[k];
            s1 = codes[k];
            wr_reg(`PEC_IDX_CTR0, 1'b0, w);
            wr_reg(`PEC_IDX_CTR1, 1'b0, 64'h0);
            exp0 = {24'h0, w[39:0]};
            exp1 = 64'h0;
            run <= 1'b1;
            tick(40);
            run <= 1'b0;
            tick(3);
            rd_reg(`PEC_IDX_CTR0, 1'b0, exp0);
            rd_reg(`PEC_IDX_CTR1, 1'b0, exp1);
            cmp_result({2'b00, exp1}, {26'h0, ctr1});
        end
        // write counter 1 and read it back in the very next clock
        w = {$urandom(), $urandom()};
        notes.push_back({2'b10, 24'h00_0000, w[39:0]});
        @(posedge clk_sys);
        wr <= 1'b1;
        idx <= `PEC_IDX_CTR1;
        wdata <= w;
        @(posedge clk_sys);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        wr_reg(32'h0000_0014, 1'b1, 64'hFFFF_FFFF_FFFF_FFFF);
        rd_reg(32'h0000_0014, 1'b1, 64'h0);
        cmp_result({26'h0, ctr0}, {2'b00, exp0});
        tick(3);
        close_out();
    end
endmodule : pec_counters_tb_top
